// ---- logic/ssd_params.svh ----
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH

`define SSD_ADDR_W         4
`define SSD_OFF_REQUEST    4'h0
`define SSD_OFF_RESPONSE   4'h4
`define SSD_OFF_DETAIL     4'h8
`define SSD_OFF_COMMCFG    4'hC

`define SSD_RESP_OUT_EN    0
`define SSD_RESP_ACTUATOR  1
`define SSD_RESP_INPUTS    4
`define SSD_RESP_LIMIT     5
`define SSD_RESP_WARN      6
`define SSD_RESP_ERROR     7

`define SSD_DET_INPUT      4
`define SSD_DET_ACTUATOR   5
`define SSD_DET_INTERNAL   6
`define SSD_DET_COMM       7

`define SSD_REQ_RESET_BIT  7
`define SSD_REQ_RESET_VAL  8'h00
`define SSD_COMMCFG_RESET  1'h1

`define SSD_CLK_HZ         50000000
`define SSD_COMM_TMO_MS    100
`define SSD_COMM_TMO_CYC   ((`SSD_CLK_HZ / 1000) * `SSD_COMM_TMO_MS)

`define SSD_RESP_OKAY      2'h0
`define SSD_RESP_SLVERR    2'h2

`endif

// ---- logic/ssd_pin_sync.sv ----
`default_nettype none
module ssd_pin_sync #(
	parameter int W = 14
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_dout;

	// Accept a change only when the last two stages agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			dout <= '0;
		end else begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			dout <= next_dout;
		end
	end
endmodule
`default_nettype wire

// ---- logic/ssd_pkg.sv ----
`default_nettype none
package ssd_pkg;
	typedef struct packed {
		logic       safetyInputA;
		logic       safetyInputB;
		logic       actuatorPresent;
		logic       actuatorValid;
		logic       limitArea;
		logic [3:0] warnCause;
		logic [3:0] errCause;
		logic       inputFault;
		logic       actuatorFault;
		logic       internalFault;
	} ssd_pins_t;

	typedef struct packed {
		logic safetyOutputA;
		logic safetyOutputB;
	} ssd_outs_t;
endpackage
`default_nettype wire

// ---- logic/ssd_status.sv ----
// Summary of operation
// (R01) While warning or error shows, a detail byte names the fault cause.
// (R02) Every status, warning and error bit is active high.
// (R03) The gateway sends one request byte per sensor; only inbound byte. The code also accepts a COMMCFG write.
// (R04) Sensor offers a response byte and a warning/error detail byte.
// (R05) One detail bit reports gateway-to-sensor communication failure.
// (R06) Status bits combine independently; no fixed code per state.
// (R07) Response bit 0 outputs enabled, bit 1 recognised actuator present.
// (R08) Response bit 4 both inputs live, bit 5 limit area.
// (R09) Response bit 6 warning with delayed switch-off, bit 7 error. The code never drops the outputs on a warning.
// (R10) Latched error clears on request bit 7 falling or guard opening.
// (R11) Unassigned response bits read zero.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`include "ssd_params.svh"
`default_nettype none
module ssd_status #(
	parameter int COMM_TIMEOUT_CYCLES = `SSD_COMM_TMO_CYC
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire ssd_pkg::ssd_pins_t sensorPins,
	output var  ssd_pkg::ssd_outs_t safetyOutputs,
	input  wire logic [3:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [3:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	ssd_pkg::ssd_pins_t pins;
	logic [15:0]        pinsVec;

	// Width follows the pin struct, all sixteen lines pass the synchroniser
	ssd_pin_sync #(.W(16)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.din    (sensorPins),
		.dout   (pinsVec)
	);
	assign pins = ssd_pkg::ssd_pins_t'(pinsVec);

	// Register index decode, shared by read and write paths
	function automatic logic [2:0] regSel(input logic [3:0] a);
		case (a)
			`SSD_OFF_REQUEST:  regSel = 3'h1;
			`SSD_OFF_RESPONSE: regSel = 3'h2;
			`SSD_OFF_DETAIL:   regSel = 3'h3;
			`SSD_OFF_COMMCFG:  regSel = 3'h4;
			default:           regSel = 3'h0;
		endcase
	endfunction

	logic [7:0]  request;
	logic [7:0]  response;
	logic [7:0]  detail;
	logic [5:0]  errLatch;
	logic        actPrev;
	logic        commFault;
	logic        commEnable;
	logic [31:0] commCnt;
	logic [7:0]  next_request;
	logic [7:0]  next_response;
	logic [7:0]  next_detail;
	logic [5:0]  next_errLatch;
	logic        next_actPrev;
	logic        next_commFault;
	logic        next_commEnable;
	logic [31:0] next_commCnt;
	ssd_pkg::ssd_outs_t next_outs;

	logic [3:0]  awAddr;
	logic        awHeld;
	logic [7:0]  wByte;
	logic        wLane0;
	logic        wHeld;
	logic [3:0]  next_awAddr;
	logic        next_awHeld;
	logic [7:0]  next_wByte;
	logic        next_wLane0;
	logic        next_wHeld;
	logic        next_awready;
	logic        next_wready;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        doWrite;
	logic        reqWrite;
	logic        cfgWrite;

	// Bus write path: address and data accepted in either order
	always_comb begin
		next_awHeld  = awHeld;
		next_awAddr  = awAddr;
		next_wHeld   = wHeld;
		next_wByte   = wByte;
		next_wLane0  = wLane0;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld  = 1'b1;
			next_wByte  = s_axi_wdata[7:0];
			next_wLane0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		doWrite  = awHeld && wHeld && !s_axi_bvalid;
		reqWrite = doWrite && wLane0 && regSel(awAddr) == 3'h1; // R03
		cfgWrite = doWrite && wLane0 && regSel(awAddr) == 3'h4;
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = (regSel(awAddr) == 3'h0) ? `SSD_RESP_SLVERR : `SSD_RESP_OKAY;
		end
		next_awready = !next_awHeld;
		next_wready  = !next_wHeld;
	end

	// Bus read path: one cycle from address to data
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = `SSD_RESP_OKAY;
			case (regSel(s_axi_araddr))
				3'h1:    next_rdata = {24'h000000, request};
				3'h2:    next_rdata = {24'h000000, response}; // R04
				3'h3:    next_rdata = {24'h000000, detail};   // R04
				3'h4:    next_rdata = {31'h00000000, commEnable};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `SSD_RESP_SLVERR;
				end
			endcase
		end
		next_arready = !next_rvalid;
	end

	logic       inputsLive;
	logic       guardOpened;
	logic       reqResetEdge;
	logic [5:0] errCauseNow;
	logic       errAny;

	// Sensor state, error latch and communication watchdog
	always_comb begin
		next_request    = reqWrite ? wByte : request;
		next_commEnable = cfgWrite ? wByte[0] : commEnable;
		next_actPrev    = pins.actuatorPresent;
		inputsLive      = pins.safetyInputA && pins.safetyInputB;
		guardOpened     = actPrev && !pins.actuatorPresent;
		reqResetEdge    = reqWrite && request[`SSD_REQ_RESET_BIT] && !wByte[`SSD_REQ_RESET_BIT];
		errCauseNow     = {pins.internalFault, pins.actuatorFault, pins.errCause};
		// Set wins: a cause still present keeps its bit latched
		next_errLatch   = errCauseNow |
			(errLatch & ~((reqResetEdge || guardOpened) ? 6'h3F : 6'h00)); // R10
		errAny          = |next_errLatch;
		// Watchdog on request traffic stands for the gateway link check
		next_commCnt    = commCnt;
		next_commFault  = commFault;
		if (reqWrite || !commEnable) begin
			next_commCnt   = 32'h00000000;
			next_commFault = 1'b0;
		end else if (commCnt >= 32'(COMM_TIMEOUT_CYCLES - 1)) begin
			next_commFault = 1'b1; // R05
		end else begin
			next_commCnt = commCnt + 32'h00000001;
		end
		// Outputs hold their state through a link fault; errors, dead inputs or an invalid actuator drop them
		next_outs.safetyOutputA = inputsLive && pins.actuatorValid && !errAny; // R02
		next_outs.safetyOutputB = next_outs.safetyOutputA;
		next_response = 8'h00; // R11 R06
		next_response[`SSD_RESP_OUT_EN]   = next_outs.safetyOutputA; // R07
		next_response[`SSD_RESP_ACTUATOR] = pins.actuatorValid;      // R07
		next_response[`SSD_RESP_INPUTS]   = inputsLive;              // R08
		next_response[`SSD_RESP_LIMIT]    = pins.limitArea;          // R08
		next_response[`SSD_RESP_WARN]     = |pins.warnCause;         // R09
		next_response[`SSD_RESP_ERROR]    = errAny;                  // R09
		next_detail = 8'h00;
		if (|pins.warnCause)
			next_detail[3:0] = pins.warnCause; // R01
		if (errAny) begin
			next_detail[3:0] = next_detail[3:0] | next_errLatch[3:0]; // R01
			next_detail[`SSD_DET_ACTUATOR] = next_errLatch[4];
			next_detail[`SSD_DET_INTERNAL] = next_errLatch[5];
		end
		next_detail[`SSD_DET_INPUT] = pins.inputFault;
		next_detail[`SSD_DET_COMM]  = next_commFault; // R05
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			awHeld        <= 1'b0;
			awAddr        <= 4'h0;
			wHeld         <= 1'b0;
			wByte         <= 8'h00;
			wLane0        <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SSD_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SSD_RESP_OKAY;
			request       <= `SSD_REQ_RESET_VAL;
			response      <= 8'h00;
			detail        <= 8'h00;
			errLatch      <= 6'h00;
			actPrev       <= 1'b0;
			commFault     <= 1'b0;
			commEnable    <= `SSD_COMMCFG_RESET;
			commCnt       <= 32'h00000000;
			safetyOutputs <= '0;
		end else begin
			awHeld        <= next_awHeld;
			awAddr        <= next_awAddr;
			wHeld         <= next_wHeld;
			wByte         <= next_wByte;
			wLane0        <= next_wLane0;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
			request       <= next_request;
			response      <= next_response;
			detail        <= next_detail;
			errLatch      <= next_errLatch;
			actPrev       <= next_actPrev;
			commFault     <= next_commFault;
			commEnable    <= next_commEnable;
			commCnt       <= next_commCnt;
			safetyOutputs <= next_outs;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	a_unused_bits_zero: assert property (response[3:2] == 2'h0) // R11
		else $error("unassigned response bits not zero");
	a_error_drops_out: assert property (response[`SSD_RESP_ERROR] |-> !response[`SSD_RESP_OUT_EN]) // R09
		else $error("outputs enabled while error shown");
	a_out_matches_pins: assert property (response[`SSD_RESP_OUT_EN] == safetyOutputs.safetyOutputA) // R07
		else $error("response bit 0 differs from safety output");
	a_out_needs_act: assert property (response[`SSD_RESP_OUT_EN] |->
		response[`SSD_RESP_ACTUATOR] && response[`SSD_RESP_INPUTS]) // R06
		else $error("outputs enabled without actuator and inputs");
	a_inputs_live_bit: assert property (response[`SSD_RESP_INPUTS] == $past(inputsLive)) // R08
		else $error("inputs live bit wrong");
	a_detail_on_fault: assert property (response[`SSD_RESP_ERROR] |-> |detail[6:0]) // R01
		else $error("error shown without detail cause");
	a_warn_has_cause: assert property (response[`SSD_RESP_WARN] |-> |detail[3:0]) // R01
		else $error("warning shown without detail cause");
	a_err_held_latched: assert property ($past(errLatch != 6'h00) && !$past(reqResetEdge) && !$past(guardOpened)
		|-> response[`SSD_RESP_ERROR]) // R10
		else $error("error cleared without reset event");
	a_comm_timeout: assert property (commEnable && !reqWrite && commCnt >= 32'(COMM_TIMEOUT_CYCLES - 1)
		|=> detail[`SSD_DET_COMM]) // R05
		else $error("communication fault not reported");
	a_active_high: assert property (response[`SSD_RESP_ERROR] == (errLatch != 6'h00)) // R02
		else $error("error bit set with no error");
	a_write_answer: assert property (doWrite |=> s_axi_bvalid)
		else $error("write not answered");
endmodule
`default_nettype wire

// ---- test/serial_diag_status_bytes_tb.sv ----
`default_nettype none
module serial_diag_status_bytes_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TMO = 20;
	logic               clk;
	logic               resetn;
	ssd_pkg::ssd_pins_t pins;
	ssd_pkg::ssd_outs_t outs;
	logic [3:0]         awaddr;
	logic [3:0]         araddr;
	logic [31:0]        wdata;
	logic [31:0]        rdata;
	logic [1:0]         bresp;
	logic [1:0]         rresp;
	logic               awvalid, awready, wvalid, wready, bvalid, bready;
	logic               arvalid, arready, rvalid, rready;
	int                 fails;
	int                 comparisons;
	logic [31:0]        rdU;
	logic [1:0]         rsU;
	logic [15:0]        pv [5] = '{16'hC000, 16'hF000, 16'hF800, 16'hF400, 16'hF020};
	logic [7:0]         rv [5] = '{8'h10, 8'h13, 8'h33, 8'h53, 8'h92};
	logic [7:0]         dv [5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h04};
	logic [1:0]         ov [5] = '{2'h0, 2'h3, 2'h3, 2'h3, 2'h0};

	ssd_status #(.COMM_TIMEOUT_CYCLES(TMO)) uut (.clk(clk), .resetn(resetn), .sensorPins(pins),
		.safetyOutputs(outs), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ssd_gw_model gw (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		gw.rd(a, d, r);
		chk(d, exp);
		chk({30'h0, r}, 32'h0);
	endtask
	task automatic wc(input logic [3:0] a, input logic [7:0] v);
		logic [1:0] r;
		gw.wr(a, v, r);
		chk({30'h0, r}, 32'h0);
	endtask
	// Fixed wait covers the pin synchroniser plus the status register
	task automatic setp(input logic [15:0] p);
		@(posedge clk);
		pins <= ssd_pkg::ssd_pins_t'(p);
		repeat (8) @(posedge clk);
	endtask
	task give_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		give_verdict();
	end
	initial begin
		fails = 0;
		comparisons = 0;
		resetn = 1'b0;
		pins = '0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		chk({30'h0, outs}, 32'h0);
		rc(4'hC, 32'h1);
		rc(4'h0, 32'h0);
		// Unmapped offsets are refused and leave the request byte alone
		gw.rd(4'h2, rdU, rsU);
		chk(rdU, 32'h0);
		chk({30'h0, rsU}, 32'h2);
		gw.wr(4'h6, 8'h80, rsU);
		chk({30'h0, rsU}, 32'h2);
		rc(4'h0, 32'h0);
		repeat (TMO + 10) @(posedge clk);
		rc(4'h8, 32'h80);
		wc(4'hC, 8'h00);
		rc(4'h8, 32'h0);
		for (int i = 0; i < 5; i++) begin
			setp(pv[i]);
			rc(4'h4, {24'h0, rv[i]});
			rc(4'h8, {24'h0, dv[i]});
			chk({30'h0, outs}, {30'h0, ov[i]});
		end
		// Cause removed, error must stay until an explicit reset
		setp(16'hF000);
		rc(4'h4, 32'h92);
		wc(4'h0, 8'h80);
		rc(4'h0, 32'h80);
		wc(4'h0, 8'h00);
		rc(4'h4, 32'h13);
		chk({30'h0, outs}, 32'h3);
		wc(4'h4, 8'hFF);
		rc(4'h4, 32'h13);
		setp(16'hF008);
		rc(4'h8, 32'h01);
		setp(16'hF000);
		rc(4'h4, 32'h92);
		setp(16'hC000);
		rc(4'h4, 32'h10);
		setp(16'hF000);
		rc(4'h4, 32'h13);
		give_verdict();
	end
endmodule
`default_nettype wire

// ---- test/ssd_gw_model.sv ----
`default_nettype none
module ssd_gw_model (
	input  wire logic        clk,
	output var  logic [3:0]  awaddr,
	output var  logic        awvalid,
	input  wire logic        awready,
	output var  logic [31:0] wdata,
	output var  logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var  logic        bready,
	output var  logic [3:0]  araddr,
	output var  logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output var  logic        rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// Request byte travels from this side to the sensor and is also read back from it
	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (!aw && !w && bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
			// Released lines flip so stale values cannot pass
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~wdata;
			end
		end
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (!arvalid && rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end
	endtask
endmodule
`default_nettype wire
